// ==== cmio_contact_mapper.v ====
// Contact input/output function mapper with terminal setting and Avalon-MM
//
// The implementer's own choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "cmio_map.vh"

module cmio_contact_mapper #(
    parameter [27:0] BLANK_CYC = `CMIO_BLANK_CYC,
    parameter [27:0] PULSE_CYC = `CMIO_PULSE_CYC,
    parameter [27:0] HOLD_CYC  = `CMIO_HOLD_CYC,
    parameter [27:0] IDLE_CYC  = `CMIO_IDLE_CYC
) (
    input  wire        sys_clk_i,
    input  wire        rst_i,
    input  wire [4:0]  avs_address_i,
    input  wire        avs_read_i,
    input  wire        avs_write_i,
    input  wire [31:0] avs_writedata_i,
    input  wire [3:0]  avs_byteenable_i,
    output reg  [31:0] avs_readdata_o,
    output reg         avs_waitrequest_o,
    input  wire [1:0]  input_contact_i,
    input  wire        key_time_up_i,
    input  wire        key_time_dn_i,
    input  wire        key_check_i,
    input  wire        key_temp_i,
    input  wire        key_reset_i,
    input  wire        key_run_i,
    input  wire        key_stop_i,
    input  wire [2:0]  term_fan_i,
    input  wire        term_heat_i,
    input  wire        unit_alarm_i,
    input  wire        unit_thermo_on_i,
    input  wire        unit_hex_run_i,
    output reg  [2:0]  output_auxiliary_relay_o,
    output reg         unit_run_o,
    output reg  [2:0]  fan_speed_o,
    output reg         heat_mode_o,
    output reg         thermo_cool_o,
    output reg         thermo_heat_o,
    output reg         setting_mode_o,
    output reg  [2:0]  sel_port_o,
    output reg  [3:0]  sel_code_o,
    output reg         store_pulse_o,
    output reg  [19:0] store_data_o
);

    localparam [3:0] ST_NORMAL = 4'h1;
    localparam [3:0] ST_MENU   = 4'h2;
    localparam [3:0] ST_UNIT   = 4'h4;
    localparam [3:0] ST_PORT   = 4'h8;

    reg  [3:0]  state_q;
    reg  [19:0] cfg_q;
    reg  [19:0] work_q;
    reg  [6:0]  keys_q;
    reg  [27:0] blank_q;
    reg         blank_done_q;
    reg  [27:0] hold_q;
    reg  [27:0] idle_q;
    reg         menu_item_q;
    reg         ctrl_nc_q;
    reg         mode_src_q;

    wire [6:0]  keys_now;
    wire [6:0]  keys_ed;
    wire        any_key;
    wire        ed_up;
    wire        ed_dn;
    wire        ed_check;
    wire        ed_temp;
    wire        ed_reset;
    wire        ed_run;
    wire        ed_stop;
    wire        idle_hit;

    wire [1:0]  c_level;
    wire [1:0]  c_close;
    wire [1:0]  c_change;
    wire [1:0]  run_ev;
    wire [1:0]  stop_ev;
    wire [1:0]  enf_act;
    wire [1:0]  tc_act;
    wire [1:0]  th_act;
    wire [1:0]  tc_on;
    wire [1:0]  th_on;
    wire [1:0]  md_act;
    wire [1:0]  md_heat;
    wire [1:0]  md_ev;
    wire        enforced;
    wire [2:0]  relay_d;

    assign keys_now = {key_stop_i, key_run_i, key_reset_i, key_temp_i,
                       key_check_i, key_time_dn_i, key_time_up_i};
    assign keys_ed  = keys_now & ~keys_q;
    assign any_key  = |keys_ed;
    assign ed_up    = keys_ed[0];
    assign ed_dn    = keys_ed[1];
    assign ed_check = keys_ed[2];
    assign ed_temp  = keys_ed[3];
    assign ed_reset = keys_ed[4];
    assign ed_run   = keys_ed[5];
    assign ed_stop  = keys_ed[6];
    assign idle_hit = (idle_q >= IDLE_CYC - 28'h0000001);

    // Power-on blanking of the contact inputs
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            blank_q      <= 28'h0000000;
            blank_done_q <= 1'b0;
        end else if (!blank_done_q) begin
            if (blank_q >= BLANK_CYC - 28'h0000001) begin
                blank_done_q <= 1'b1;
            end else begin
                blank_q <= blank_q + 28'h0000001;
            end
        end
    end

    // Per-input qualification and function decode
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_in
            wire [3:0] code;
            assign code = cfg_q[gi*4 +: 4];
            cmio_contact_filter #(
                .MIN_CYC (PULSE_CYC)
            ) u_filt (
                .sys_clk_i (sys_clk_i),
                .rst_i     (rst_i),
                .raw_i     (input_contact_i[gi]),
                .gate_i    (blank_done_q),
                .level_o   (c_level[gi]),
                .close_o   (c_close[gi]),
                .change_o  (c_change[gi])
            );
            assign run_ev[gi]  =
                ((code == `CMIO_IN_LEVEL) & c_change[gi] & c_level[gi]) |
                ((code == `CMIO_IN_PULSE_RUN) & c_close[gi]);
            assign stop_ev[gi] =
                ((code == `CMIO_IN_LEVEL) & c_change[gi] & ~c_level[gi]) |
                ((code == `CMIO_IN_PULSE_STOP) & c_close[gi]);
            assign enf_act[gi] = (code == `CMIO_IN_ENFORCE) & blank_done_q &
                                 (c_level[gi] ^ ctrl_nc_q);
            assign tc_act[gi]  = (code == `CMIO_IN_TH_COOL);
            assign th_act[gi]  = (code == `CMIO_IN_TH_HEAT);
            assign tc_on[gi]   = tc_act[gi] & c_level[gi];
            assign th_on[gi]   = th_act[gi] & c_level[gi];
            assign md_act[gi]  = (code == `CMIO_IN_MODE);
            assign md_heat[gi] = md_act[gi] & c_level[gi];
            assign md_ev[gi]   = md_act[gi] & c_change[gi];
        end
    endgenerate

    assign enforced = |enf_act;

    // Relay drive per output port
    genvar go;
    generate
        for (go = 0; go < 3; go = go + 1) begin : g_out
            wire [3:0] code;
            reg        drv;
            assign code = cfg_q[(go+2)*4 +: 4];
            always @* begin
                drv = 1'b0;
                case (code)
                    `CMIO_OUT_RUN:     drv = unit_run_o;
                    `CMIO_OUT_ALARM:   drv = unit_alarm_i;
                    `CMIO_OUT_COOL:    drv = unit_run_o & ~heat_mode_o;
                    `CMIO_OUT_TH_COOL: drv = unit_run_o & ~heat_mode_o &
                                             unit_thermo_on_i;
                    `CMIO_OUT_HEAT:    drv = unit_run_o & heat_mode_o;
                    `CMIO_OUT_TH_HEAT: drv = unit_run_o & heat_mode_o &
                                             unit_thermo_on_i;
                    `CMIO_OUT_HEX:     drv = unit_hex_run_i;
                    default:           drv = 1'b0;
                endcase
            end
            assign relay_d[go] = drv;
        end
    endgenerate

    // Run state, fan speed, mode and thermostat requests
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            unit_run_o               <= 1'b0;
            fan_speed_o              <= 3'h0;
            heat_mode_o              <= 1'b0;
            mode_src_q               <= 1'b0;
            thermo_cool_o            <= 1'b1;
            thermo_heat_o            <= 1'b1;
            output_auxiliary_relay_o <= 3'h0;
        end else begin
            output_auxiliary_relay_o <= relay_d;
            if (enforced) begin
                unit_run_o <= 1'b0;
            end else if (ed_stop | (|stop_ev)) begin
                unit_run_o <= 1'b0;
            end else if (|run_ev) begin
                unit_run_o  <= 1'b1;
                fan_speed_o <= term_fan_i;
            end else if (ed_run) begin
                unit_run_o  <= 1'b1;
                fan_speed_o <= term_fan_i;
            end
            if (|md_ev) begin
                mode_src_q <= 1'b1;
            end else if (term_heat_i != heat_mode_o && !mode_src_q) begin
                mode_src_q <= 1'b0;
            end
            if (|md_ev) begin
                heat_mode_o <= |md_heat;
            end else if (!(|md_act) || !mode_src_q) begin
                heat_mode_o <= term_heat_i;
            end
            thermo_cool_o <= (|tc_act) ? (|tc_on) : 1'b1;
            thermo_heat_o <= (|th_act) ? (|th_on) : 1'b1;
        end
    end

    // Terminal setting sequence
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q       <= ST_NORMAL;
            cfg_q         <= `CMIO_DEF_CODES;
            work_q        <= `CMIO_DEF_CODES;
            keys_q        <= 7'h00;
            hold_q        <= 28'h0000000;
            idle_q        <= 28'h0000000;
            menu_item_q   <= 1'b0;
            sel_port_o    <= 3'h0;
            store_pulse_o <= 1'b0;
            store_data_o  <= `CMIO_DEF_CODES;
        end else begin
            keys_q        <= keys_now;
            store_pulse_o <= 1'b0;
            if (any_key || state_q == ST_NORMAL) begin
                idle_q <= 28'h0000000;
            end else if (!idle_hit) begin
                idle_q <= idle_q + 28'h0000001;
            end
            case (state_q)
                ST_NORMAL: begin
                    if (key_check_i && key_reset_i && !unit_run_o) begin
                        if (hold_q >= HOLD_CYC - 28'h0000001) begin
                            state_q     <= ST_MENU;
                            menu_item_q <= 1'b0;
                            hold_q      <= 28'h0000000;
                        end else begin
                            hold_q <= hold_q + 28'h0000001;
                        end
                    end else begin
                        hold_q <= 28'h0000000;
                    end
                end
                ST_MENU: begin
                    if (ed_temp) begin
                        menu_item_q <= ~menu_item_q;
                    end else if ((ed_check || idle_hit) && !key_reset_i) begin
                        if (menu_item_q) begin
                            state_q <= ST_UNIT;
                            work_q  <= cfg_q;
                        end else begin
                            state_q <= ST_NORMAL;
                        end
                    end else if (ed_reset) begin
                        state_q <= ST_NORMAL;
                    end
                end
                ST_UNIT: begin
                    if (ed_check || idle_hit) begin
                        state_q    <= ST_PORT;
                        sel_port_o <= 3'h0;
                    end else if (ed_reset) begin
                        state_q <= ST_NORMAL;
                    end
                end
                ST_PORT: begin
                    if (ed_reset) begin
                        cfg_q         <= work_q;
                        store_data_o  <= work_q;
                        store_pulse_o <= 1'b1;
                        state_q       <= ST_NORMAL;
                    end else if (ed_temp) begin
                        state_q <= ST_UNIT;
                    end else if (ed_up) begin
                        sel_port_o <= (sel_port_o == `CMIO_PORT_LAST) ?
                                      3'h0 : sel_port_o + 3'h1;
                    end else if (ed_dn) begin
                        sel_port_o <= (sel_port_o == 3'h0) ?
                                      `CMIO_PORT_LAST : sel_port_o - 3'h1;
                    end else if (ed_check) begin
                        work_q[sel_port_o*4 +: 4] <=
                            (work_q[sel_port_o*4 +: 4] == `CMIO_CODE_LAST) ?
                            4'h0 : work_q[sel_port_o*4 +: 4] + 4'h1;
                    end
                end
                default: begin
                    state_q <= ST_NORMAL;
                end
            endcase
        end
    end

    // Display of setting state
    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            setting_mode_o <= 1'b0;
            sel_code_o     <= 4'h0;
        end else begin
            setting_mode_o <= (state_q == ST_PORT);
            sel_code_o     <= work_q[sel_port_o*4 +: 4];
        end
    end

    // Avalon-MM slave, one wait state per access
    wire [2:0] reg_idx;
    wire       acc;
    assign reg_idx = avs_address_i[4:2];
    assign acc     = avs_read_i | avs_write_i;

    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= 32'h00000000;
            ctrl_nc_q         <= `CMIO_CTRL_RST;
        end else begin
            if (acc && avs_waitrequest_o) begin
                avs_waitrequest_o <= 1'b0;
                case (reg_idx)
                    `CMIO_REG_CTRL:
                        avs_readdata_o <= {31'h00000000, ctrl_nc_q};
                    `CMIO_REG_STATUS:
                        avs_readdata_o <= {24'h000000, state_q,
                                           blank_done_q, enforced,
                                           heat_mode_o, unit_run_o};
                    `CMIO_REG_ASSIGN:
                        avs_readdata_o <= {12'h000, cfg_q};
                    `CMIO_REG_WORK:
                        avs_readdata_o <= {12'h000, work_q};
                    `CMIO_REG_PINS:
                        avs_readdata_o <= {24'h000000, fan_speed_o,
                                           output_auxiliary_relay_o,
                                           c_level};
                    default:
                        avs_readdata_o <= 32'h00000000;
                endcase
            end else begin
                avs_waitrequest_o <= 1'b1;
            end
            if (avs_write_i && !avs_waitrequest_o &&
                reg_idx == `CMIO_REG_CTRL && avs_byteenable_i[0]) begin
                ctrl_nc_q <= avs_writedata_i[`CMIO_CTRL_NC_BIT];
            end
        end
    end

endmodule // cmio_contact_mapper
`default_nettype wire

// ==== cmio_map.vh ====
// Constants of the contact function mapper
`ifndef CMIO_MAP_VH
`define CMIO_MAP_VH

// Clock rate and documented times
`define CMIO_CLK_HZ        20000000
`define CMIO_BLANK_S       10
`define CMIO_PULSE_MS      200
`define CMIO_HOLD_S        3
`define CMIO_IDLE_S        7
`define CMIO_BLANK_CYC     (`CMIO_CLK_HZ * `CMIO_BLANK_S)
`define CMIO_PULSE_CYC     ((`CMIO_CLK_HZ / 1000) * `CMIO_PULSE_MS)
`define CMIO_HOLD_CYC      (`CMIO_CLK_HZ * `CMIO_HOLD_S)
`define CMIO_IDLE_CYC      (`CMIO_CLK_HZ * `CMIO_IDLE_S)

// Register word indices, decoded from avs_address_i[4:2]
`define CMIO_REG_CTRL      3'h0
`define CMIO_REG_STATUS    3'h1
`define CMIO_REG_ASSIGN    3'h2
`define CMIO_REG_WORK      3'h3
`define CMIO_REG_PINS      3'h4
`define CMIO_CTRL_RST      1'h0

// Control fields
`define CMIO_CTRL_NC_BIT   0

// Function codes, input side
`define CMIO_IN_NONE       4'h0
`define CMIO_IN_TH_COOL    4'h1
`define CMIO_IN_TH_HEAT    4'h2
`define CMIO_IN_LEVEL      4'h3
`define CMIO_IN_PULSE_RUN  4'h4
`define CMIO_IN_PULSE_STOP 4'h5
`define CMIO_IN_ENFORCE    4'h6
`define CMIO_IN_MODE       4'h7

// Function codes, output side
`define CMIO_OUT_NONE      4'h0
`define CMIO_OUT_RUN       4'h1
`define CMIO_OUT_ALARM     4'h2
`define CMIO_OUT_COOL      4'h3
`define CMIO_OUT_TH_COOL   4'h4
`define CMIO_OUT_HEAT      4'h5
`define CMIO_OUT_TH_HEAT   4'h6
`define CMIO_OUT_HEX       4'h7
`define CMIO_CODE_LAST     4'h7

// Ports and shipment defaults, port 0 in the low nibble
`define CMIO_PORT_LAST     3'h4
`define CMIO_DEF_CODES     20'h62163

`endif

// ==== cmio_contact_filter.v ====
// Contact qualifier: minimum-width filter with closing and change events
`timescale 1ns/1ps
`default_nettype none
`include "cmio_map.vh"

module cmio_contact_filter #(
    parameter [27:0] MIN_CYC = `CMIO_PULSE_CYC
) (
    input  wire        sys_clk_i,
    input  wire        rst_i,
    input  wire        raw_i,
    input  wire        gate_i,
    output reg         level_o,
    output reg         close_o,
    output reg         change_o
);

    reg [27:0] cnt_q;

    always @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q    <= 28'h0000000;
            level_o  <= 1'b0;
            close_o  <= 1'b0;
            change_o <= 1'b0;
        end else begin
            close_o  <= 1'b0;
            change_o <= 1'b0;
            if (!gate_i) begin
                cnt_q   <= 28'h0000000;
                level_o <= 1'b0;
            end else if (raw_i == level_o) begin
                cnt_q <= 28'h0000000;
            end else if (cnt_q >= MIN_CYC - 28'h0000001) begin
                // Accept new level once held long enough
                cnt_q    <= 28'h0000000;
                level_o  <= raw_i;
                change_o <= 1'b1;
                close_o  <= raw_i;
            end else begin
                cnt_q <= cnt_q + 28'h0000001;
            end
        end
    end

endmodule // cmio_contact_filter
`default_nettype wire

// ==== cmio_contact_mapper_chk.sv ====
// Port checker for the contact function mapper
`timescale 1ns/1ps
`default_nettype none
module cmio_contact_mapper_chk #(
    parameter [27:0] BLANK_CYC = 28'h14,
    parameter [27:0] PULSE_CYC = 28'h4
) (
    input wire logic        sys_clk_i,
    input wire logic        rst_i,
    input wire logic [4:0]  avs_address_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0]  avs_byteenable_i,
    input wire logic        avs_waitrequest_o,
    input wire logic [1:0]  input_contact_i,
    input wire logic        key_temp_i,
    input wire logic        key_reset_i,
    input wire logic        key_run_i,
    input wire logic [2:0]  term_fan_i,
    input wire logic [2:0]  output_auxiliary_relay_o,
    input wire logic        unit_run_o,
    input wire logic [2:0]  fan_speed_o,
    input wire logic        setting_mode_o,
    input wire logic [2:0]  sel_port_o,
    input wire logic [3:0]  sel_code_o,
    input wire logic        store_pulse_o,
    input wire logic [19:0] store_data_o
);
    logic [27:0] blank_q, enf_q;
    logic        nc_q, ran_q, pm_q, pm2_q;
    logic [2:0]  pp_q, pp2_q;
    logic [3:0]  pc_q;
    wire         done_w = blank_q == BLANK_CYC;
    wire         ctl_w = avs_write_i && !avs_waitrequest_o
                         && avs_byteenable_i[0] && avs_address_i[4:2] == 3'h0;
    wire         act_w = done_w && (input_contact_i[1] ^ nc_q);

    // Reference counters and history
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            blank_q <= 28'h0;
            enf_q   <= 28'h0;
            nc_q    <= 1'b0;
            ran_q   <= 1'b0;
            pm_q    <= 1'b0;
            pm2_q   <= 1'b0;
            pp_q    <= 3'h0;
            pp2_q   <= 3'h0;
            pc_q    <= 4'h0;
        end else begin
            blank_q <= done_w ? blank_q : blank_q + 28'h1;
            nc_q    <= ctl_w ? avs_writedata_i[0] : nc_q;
            enf_q   <= act_w ? enf_q + 28'h1 : 28'h0;
            ran_q   <= ran_q | key_run_i;
            pm_q    <= setting_mode_o;
            pm2_q   <= pm_q;
            pp_q    <= sel_port_o;
            pp2_q   <= pp_q;
            pc_q    <= sel_code_o;
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    property p_defaults;
        $fell(rst_i) |-> store_data_o == 20'h62163;
    endproperty
    a_defaults: assert property (p_defaults)
        else $error("Default codes wrong");
    property p_blank;
        !done_w && !ran_q |-> !unit_run_o;
    endproperty
    a_blank: assert property (p_blank)
        else $error("Unit ran during blanking");
    property p_fan;
        $rose(unit_run_o) |-> fan_speed_o == $past(term_fan_i);
    endproperty
    a_fan: assert property (p_fan)
        else $error("Fan not taken");
    property p_relay;
        store_data_o[11:8] == 4'h1
            |-> output_auxiliary_relay_o[0] == $past(unit_run_o);
    endproperty
    a_relay: assert property (p_relay)
        else $error("Run relay wrong");
    property p_enforce;
        enf_q > PULSE_CYC + 28'h4 && store_data_o[7:4] == 4'h6
            |-> !unit_run_o;
    endproperty
    a_enforce: assert property (p_enforce)
        else $error("Ran when enforced");
    property p_port;
        pm_q && setting_mode_o && sel_port_o != pp_q
            |-> sel_port_o == (pp_q == 3'h4 ? 3'h0 : pp_q + 3'h1)
             || sel_port_o == (pp_q == 3'h0 ? 3'h4 : pp_q - 3'h1);
    endproperty
    a_port: assert property (p_port)
        else $error("Port did not step by one");
    property p_code;
        pm_q && pm2_q && setting_mode_o && sel_port_o == pp_q
            && pp_q == pp2_q && sel_code_o != pc_q
            |-> sel_code_o == (pc_q == 4'h7 ? 4'h0 : pc_q + 4'h1);
    endproperty
    a_code: assert property (p_code)
        else $error("Code did not step by one");
    property p_temp;
        setting_mode_o && $rose(key_temp_i) && !key_reset_i
            |-> ##[1:4] !setting_mode_o;
    endproperty
    a_temp: assert property (p_temp)
        else $error("Temp key kept setting");
    property p_store;
        setting_mode_o && $rose(key_reset_i)
            |-> ##[1:4] store_pulse_o ##1 !store_pulse_o;
    endproperty
    a_store: assert property (p_store)
        else $error("Reset key did not store once");

    c_store: cover property (store_pulse_o);
    c_run: cover property ($rose(unit_run_o));
    c_wrap: cover property (setting_mode_o && sel_port_o == 3'h4);
endmodule // cmio_contact_mapper_chk

bind cmio_contact_mapper cmio_contact_mapper_chk #(
    .BLANK_CYC(BLANK_CYC), .PULSE_CYC(PULSE_CYC)
) u_chk (.*);
`default_nettype wire

// ==== cmio_bms_model.sv ====
// Building supervisor contacts: held levels and timed closures
`timescale 1ns/1ps
`default_nettype none
module cmio_bms_model #(
    parameter int PULSE_CYC = 4
) (
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    input  wire logic [1:0] level_i,
    input  wire logic [1:0] pulse_i,
    output logic      [1:0] contact_o
);
    int cnt_q [2];

    // Closure held past the minimum width
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q[0] <= 0;
            cnt_q[1] <= 0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (pulse_i[i])
                    cnt_q[i] <= PULSE_CYC + 3;
                else if (cnt_q[i] > 0)
                    cnt_q[i] <= cnt_q[i] - 1;
            end
        end
    end
    assign contact_o = level_i | {cnt_q[1] != 0, cnt_q[0] != 0};
endmodule // cmio_bms_model
`default_nettype wire

// ==== cmio_tb.sv ====
// Self-checking bench for the contact function mapper
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct {logic [4:0] a; logic [31:0] v;} cmio_row_t;
    logic        clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0;
    logic        alarm = 1'b0, heat = 1'b0, tho = 1'b0, hx = 1'b0;
    logic [4:0]  adr = 5'h00;
    logic [31:0] wd = 32'h0, q;
    logic [6:0]  keys = 7'h00;
    logic [2:0]  fan = 3'h5;
    logic [3:0]  be = 4'hF;
    logic [1:0]  lvl = 2'h0, pls = 2'h0;
    wire  [1:0]  contact;
    wire  [31:0] rdata;
    wire  [2:0]  relay, fan_o, sport;
    wire         wreq, run, smode, spulse, hm, tc, thh;
    wire  [3:0]  scode;
    wire  [19:0] sdata;
    int          num_errors = 0, checks = 0, cyc = 0;
    cmio_row_t   rows [5] = '{'{5'h00, 32'h0}, '{5'h04, 32'h18},
        '{5'h08, 32'h62163}, '{5'h10, 32'h0}, '{5'h14, 32'h0}};

    cmio_contact_mapper #(.BLANK_CYC(28'h14), .PULSE_CYC(28'h4),
        .HOLD_CYC(28'h8), .IDLE_CYC(28'h1E)) dut (
        .sys_clk_i(clk), .rst_i(rst), .avs_address_i(adr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
        .avs_byteenable_i(be), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wreq), .input_contact_i(contact),
        .key_time_up_i(keys[0]), .key_time_dn_i(keys[1]),
        .key_check_i(keys[2]), .key_temp_i(keys[3]),
        .key_reset_i(keys[4]), .key_run_i(keys[5]), .key_stop_i(keys[6]),
        .term_fan_i(fan), .term_heat_i(heat), .unit_alarm_i(alarm),
        .unit_thermo_on_i(tho), .unit_hex_run_i(hx),
        .output_auxiliary_relay_o(relay), .unit_run_o(run),
        .fan_speed_o(fan_o), .heat_mode_o(hm), .thermo_cool_o(tc),
        .thermo_heat_o(thh), .setting_mode_o(smode), .sel_port_o(sport),
        .sel_code_o(scode), .store_pulse_o(spulse), .store_data_o(sdata));
    cmio_bms_model #(.PULSE_CYC(4)) u_bms (.sys_clk_i(clk), .rst_i(rst),
        .level_i(lvl), .pulse_i(pls), .contact_o(contact));

    always #25 clk = ~clk;

    task automatic test_done;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic cmp(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        adr <= a;
        wr <= w;
        rd <= !w;
        wd <= d;
        do begin
            @(posedge clk);
            n++;
        end while (wreq !== 1'b0 && n < 20);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 20)
            num_errors++;
    endtask

    task automatic press(input int k);
        @(posedge clk);
        keys[k] <= 1'b1;
        wt(2);
        keys[k] <= 1'b0;
        wt(5);
    endtask

    task automatic pulse(input logic [1:0] b);
        pls <= b;
        @(posedge clk);
        pls <= 2'h0;
        wt(12);
    endtask

    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            num_errors++;
            test_done();
        end
    end

    initial begin
        wt(10);
        rst <= 1'b0;
        lvl <= 2'h1;
        wt(10);
        lvl <= 2'h0;
        wt(20);
        cmp("run in blanking", run, 32'h0);
        cmp("thermo", {hm, tc, thh}, 32'h3);
        foreach (rows[i]) begin
            bus(1'b0, rows[i].a, 32'h0);
            cmp("register", q, rows[i].v);
        end
        $display("registers and blanking done");
        lvl <= 2'h1;
        wt(2);
        lvl <= 2'h0;
        wt(10);
        cmp("glitch run", run, 32'h0);
        fan <= 3'h2;
        lvl <= 2'h1;
        wt(10);
        cmp("level run", run, 32'h1);
        cmp("fan speed", fan_o, 32'h2);
        cmp("run relay", relay, 32'h1);
        press(6);
        cmp("key stop", run, 32'h0);
        press(5);
        cmp("key run", run, 32'h1);
        lvl <= 2'h0;
        wt(10);
        cmp("level stop", run, 32'h0);
        alarm <= 1'b1;
        wt(4);
        cmp("alarm relay", relay, 32'h2);
        alarm <= 1'b0;
        $display("level and relays done");
        lvl <= 2'h2;
        wt(10);
        press(5);
        cmp("enforced run", run, 32'h0);
        bus(1'b1, 5'h00, 32'h1);
        bus(1'b0, 5'h00, 32'h0);
        cmp("sense", q, 32'h1);
        lvl <= 2'h0;
        wt(10);
        press(5);
        cmp("closed sense open", run, 32'h0);
        lvl <= 2'h2;
        wt(10);
        press(5);
        cmp("closed sense shut", run, 32'h1);
        press(6);
        bus(1'b1, 5'h00, 32'h0);
        lvl <= 2'h0;
        wt(10);
        $display("enforced stop done");
        keys <= 7'h14;
        wt(12);
        keys <= 7'h00;
        wt(4);
        press(3);
        press(2);
        press(2);
        cmp("setting", smode, 32'h1);
        cmp("first code", scode, 32'h3);
        press(1);
        cmp("port down", sport, 32'h4);
        press(0);
        cmp("port up", sport, 32'h0);
        press(2);
        press(2);
        cmp("code", scode, 32'h5);
        press(0);
        cmp("second code", scode, 32'h6);
        for (int i = 1; i <= 6; i++) begin
            press(2);
            cmp("code step", scode, 32'((6 + i) % 8));
        end
        press(3);
        cmp("left setting", smode, 32'h0);
        press(2);
        cmp("edit kept", scode, 32'h5);
        press(4);
        cmp("stored", sdata, 32'h62145);
        cmp("normal", smode, 32'h0);
        bus(1'b0, 5'h08, 32'h0);
        cmp("assign", q, 32'h62145);
        $display("port setting done");
        pulse(2'h2);
        cmp("pulse run", run, 32'h1);
        pulse(2'h1);
        cmp("pulse stop", run, 32'h0);
        lvl <= 2'h2;
        wt(10);
        press(6);
        wt(10);
        cmp("one event", run, 32'h0);
        press(5);
        rst <= 1'b1;
        wt(2);
        rst <= 1'b0;
        wt(1);
        cmp("reset run", run, 32'h0);
        cmp("reset codes", sdata, 32'h62163);
        lvl <= 2'h0;
        $display("pulse and reset done");
        test_done();
    end
endmodule // testbench
`default_nettype wire
